// *** verilog/efb_regs.svh ***
// Constants for the endpoint FIFO buffer and its external interface
`ifndef EFB_REGS_SVH
`define EFB_REGS_SVH

// Memory organisation
`define EFB_BLOCKS 8
`define EFB_BLK_W 3
`define EFB_BLOCK_WORDS 256
`define EFB_PTR_W 8
`define EFB_CNT_W 9
`define EFB_WORD_W 16
`define EFB_FIFOS 4
`define EFB_STAGE_DEPTH 16
`define EFB_READY_N 6

// Synchronised pin vector layout
`define EFB_PIN_CLK 0
`define EFB_PIN_CS 1
`define EFB_PIN_RD 2
`define EFB_PIN_WR 3
`define EFB_PIN_OE 4
`define EFB_PIN_PE 5
`define EFB_PIN_ADDR 6
`define EFB_PIN_DATA 8
`define EFB_PIN_RDY 24
`define EFB_PIN_W 30

// Stage entry layout: fifo index, has data, packet end, data
`define EFB_ENT_PE 16
`define EFB_ENT_HAS 17
`define EFB_ENT_FIFO 18
`define EFB_ENT_W 20

// Clock rates in MHz
`define EFB_REF_MHZ 40
`define EFB_IFACE_CLK_SLOW_MHZ 30
`define EFB_IFACE_CLK_FAST_MHZ 48

// Endpoint sizes in bytes
`define EFB_EP_NONE 10'h000
`define EFB_EP_SMALL 10'h040
`define EFB_EP_LARGE 10'h200

`endif

// *** verilog/efb_pkg.sv ***
// Types shared by the endpoint FIFO buffer design
package efb_pkg;
	`include "efb_regs.svh"

	// Waveform engine states, Gray along IDLE, ADDR, XFER, NEXT
	typedef enum logic [1:0] {
		EFB_MST_IDLE = 2'h0,
		EFB_MST_ADDR = 2'h1,
		EFB_MST_XFER = 2'h3,
		EFB_MST_NEXT = 2'h2
	} efb_mst_t;

	// Endpoint transfer type reported
	typedef enum logic [1:0] {
		EFB_EP_CTRL = 2'h0,
		EFB_EP_BULK = 2'h1,
		EFB_EP_INTR = 2'h2,
		EFB_EP_ISO = 2'h3
	} efb_ep_type_t;

	// Registered state of the top module, apart from the RAM, its read ports and the staging FIFO
	typedef struct packed {
		logic [1:0] rstPipe;
		logic [`EFB_PIN_W-1:0] sync1;
		logic [`EFB_PIN_W-1:0] sync2;
		logic clkPrev;
		logic [`EFB_FIFOS-1:0][1:0] curIdx;
		logic [`EFB_FIFOS-1:0][`EFB_PTR_W-1:0] ioPtr;
		logic [`EFB_BLOCKS-1:0] owner;
		logic [`EFB_BLOCKS-1:0][`EFB_CNT_W-1:0] wordCount;
		logic dataOe_n;
		logic flagSecond;
		logic flagThird;
		logic [1:0] addrOut;
		logic addrOe_n;
		efb_mst_t mst;
		logic strobe;
		logic [7:0] divCnt;
		logic clkOut;
		logic clkOe_n;
		logic [9:0] epSize;
		efb_ep_type_t epType;
		logic epDouble;
		logic giveRefused;
	} efb_state_t;
endpackage

// *** verilog/efb_stream_fifo.sv ***
// Small valid/ready FIFO staging words on their way into block RAM
`timescale 1ns/1ps
module efb_stream_fifo #(
	parameter int WIDTH = 20,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Filling side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// Draining side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);

	// Pointers with one wrap bit
	typedef struct packed {
		logic [AW:0] wrPtr;
		logic [AW:0] rdPtr;
	} efb_fifo_state_t;

	efb_fifo_state_t s_reg;
	efb_fifo_state_t s_next;
	logic [WIDTH-1:0] store [0:DEPTH-1];
	logic pushOk;
	logic popOk;

	// Full when pointers differ only in the wrap bit
	assign inReady = (s_reg.wrPtr ^ s_reg.rdPtr) != {1'b1, {AW{1'b0}}};
	assign outValid = s_reg.wrPtr != s_reg.rdPtr;
	assign outData = store[s_reg.rdPtr[AW-1:0]];
	assign pushOk = inValid & inReady;
	assign popOk = outValid & outReady;

	// Pointer advance
	always_comb begin
		s_next = s_reg;
		if (pushOk) begin
			s_next.wrPtr = s_reg.wrPtr + 1'b1;
		end
		if (popOk) begin
			s_next.rdPtr = s_reg.rdPtr + 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// Word storage, no reset needed
	always_ff @(posedge clk) begin
		if (pushOk) begin
			store[s_reg.wrPtr[AW-1:0]] <= inData;
		end
	end
endmodule

// *** verilog/efb_endpoint_fifo.sv ***
// Endpoint block RAM, domain switching, slave FIFO port and waveform engine
`timescale 1ns/1ps
`include "efb_regs.svh"
module efb_endpoint_fifo #(
	parameter int STAGE_DEPTH = `EFB_STAGE_DEPTH,
	parameter int READY_N = `EFB_READY_N
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Configuration
	input wire logic ifaceMasterMode,
	input wire logic ifaceInternalClk,
	input wire logic ifaceClkFast,
	input wire logic [`EFB_FIFOS-1:0][1:0] fifoDepthSel,
	input wire logic [1:0] altSetting,
	input wire logic highSpeed,
	input wire logic [2:0] epQuery,
	// USB serial engine side
	input wire logic [`EFB_BLK_W-1:0] usbBlock,
	input wire logic [`EFB_PTR_W-1:0] usbAddr,
	input wire logic usbWrite,
	input wire logic [`EFB_WORD_W-1:0] usbWrData,
	input wire logic usbGive,
	input wire logic [`EFB_CNT_W-1:0] usbGiveCount,
	output logic [`EFB_WORD_W-1:0] usbRdData,
	output logic [`EFB_BLOCKS-1:0] blockOwner,
	output logic giveRefused,
	// Interface clock pin
	input wire logic ifaceClkIn,
	output logic ifaceClkOut,
	output logic ifaceClkOe_n,
	// Slave FIFO strobes
	input wire logic fifoChipSelect_n,
	input wire logic fifoReadStrobe,
	input wire logic fifoWriteStrobe,
	input wire logic fifoOutputEnable,
	input wire logic packetEndStrobe,
	// FIFO select address pins
	input wire logic [1:0] fifoSelectAddrIn,
	output logic [1:0] fifoSelectAddrOut,
	output logic fifoSelectAddrOe_n,
	// Data pins
	input wire logic [`EFB_WORD_W-1:0] fifoDataIn,
	output logic [`EFB_WORD_W-1:0] fifoDataOut,
	output logic fifoDataOe_n,
	// Flags, ready inputs and engine strobe
	input wire logic [READY_N-1:0] readyIn,
	output logic fifoFlagSecond,
	output logic fifoFlagThird,
	output logic waveStrobe,
	// Endpoint size report
	output logic [9:0] epSize,
	output efb_pkg::efb_ep_type_t epType,
	output logic epDouble
);
	import efb_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Constants

	// Half period of the generated interface clock in reference cycles
	localparam int HALF_SLOW_RAW = `EFB_REF_MHZ / (2 * `EFB_IFACE_CLK_SLOW_MHZ);
	localparam int HALF_FAST_RAW = `EFB_REF_MHZ / (2 * `EFB_IFACE_CLK_FAST_MHZ);
	localparam logic [7:0] HALF_SLOW = 8'((HALF_SLOW_RAW < 1) ? 1 : HALF_SLOW_RAW);
	localparam logic [7:0] HALF_FAST = 8'((HALF_FAST_RAW < 1) ? 1 : HALF_FAST_RAW);
	localparam int MEM_WORDS = `EFB_BLOCKS * `EFB_BLOCK_WORDS;
	// Reset image of the state: pins released, flags show an empty FIFO
	localparam efb_state_t STATE_RESET = '{dataOe_n: 1'b1, flagThird: 1'b1, addrOe_n: 1'b1,
		clkOe_n: 1'b1, mst: EFB_MST_IDLE, epType: EFB_EP_CTRL, default: '0};

	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	efb_state_t s_reg, s_next; // Registered state and its next value
	logic rst_n; // Synchronised reset
	logic [`EFB_PIN_W-1:0] pinsRaw; // Pins from outside the clock domain
	// Eight blocks of 256 words, block number in the upper address bits
	logic [`EFB_WORD_W-1:0] ram [0:MEM_WORDS-1];
	logic [`EFB_WORD_W-1:0] ioRd_reg, usbRd_reg; // I/O and USB read ports
	logic [`EFB_FIFOS-1:0][`EFB_BLK_W-1:0] base; // First block of each FIFO
	logic [1:0] sel, dFifo; // Active FIFO, FIFO of the entry being drained
	logic [`EFB_BLK_W-1:0] blk, dBlk; // Current block of each of those
	logic isIn, tick; // Active FIFO moves data toward USB; interface clock edge
	logic opRd, opWr, opPe; // Read, write and packet end this cycle
	logic stageInValid, stageInReady, stageOutValid, stageOutReady; // Staging handshakes
	logic [`EFB_ENT_W-1:0] stageIn, stageOut; // Entries into and out of staging
	logic drainWrite; // Entry data lands in RAM

	////////////////////////////////////////////////////////////////////////////////
	// Endpoint report table

	// Size, type and double buffering for one endpoint
	function automatic logic [12:0] ep_report(input logic [2:0] q, input logic [1:0] alt,
			input logic hs);
		logic [9:0] big;
		logic [9:0] size;
		efb_ep_type_t typ;
		logic dbl;
		big = hs ? `EFB_EP_LARGE : `EFB_EP_SMALL;
		size = big;
		typ = EFB_EP_BULK;
		dbl = 1'b1;
		if (q == 3'h0) begin
			size = `EFB_EP_SMALL;
			typ = EFB_EP_CTRL;
			dbl = 1'b0;
		end else if (alt == 2'h0) begin
			size = `EFB_EP_NONE;
			typ = EFB_EP_CTRL;
			dbl = 1'b0;
		end else if (q == 3'h1 || q == 3'h2) begin
			// Endpoint 1 holds 64 bytes even where 512 is reported
			dbl = 1'b0;
			if (alt == 2'h1) begin
				size = big;
			end else begin
				size = `EFB_EP_SMALL;
				typ = EFB_EP_INTR;
			end
		end else if (q == 3'h3 || q == 3'h5) begin
			// Endpoints 2 and 6 follow the setting
			if (alt == 2'h2) begin
				typ = EFB_EP_INTR;
			end else if (alt == 2'h3) begin
				typ = EFB_EP_ISO;
			end
		end
		return {size, typ, dbl};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Reset release and pin gathering

	assign rst_n = s_reg.rstPipe[1];
	assign pinsRaw = {readyIn[`EFB_READY_N-1:0], fifoDataIn, fifoSelectAddrIn, packetEndStrobe,
		fifoOutputEnable, fifoWriteStrobe, fifoReadStrobe, fifoChipSelect_n, ifaceClkIn};

	////////////////////////////////////////////////////////////////////////////////
	// Staging FIFO toward the RAM

	// Write data waits here until its block belongs to the I/O side
	efb_stream_fifo #(
		.WIDTH(`EFB_ENT_W),
		.DEPTH(STAGE_DEPTH)
	) u_stage (
		.clk(ref_clk),
		.rst_n(rst_n),
		.inValid(stageInValid),
		.inReady(stageInReady),
		.inData(stageIn),
		.outValid(stageOutValid),
		.outReady(stageOutReady),
		.outData(stageOut)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic

	always_comb begin
		s_next = s_reg;
		s_next.rstPipe = {s_reg.rstPipe[0], 1'b1}; // Release shifts in ones
		// Two-flop capture of every pin
		s_next.sync1 = pinsRaw;
		s_next.sync2 = s_reg.sync1;
		s_next.clkPrev = s_reg.sync2[`EFB_PIN_CLK];

		// Buffer chains laid end to end over the eight blocks
		base[0] = '0;
		for (int k = 1; k < `EFB_FIFOS; k++) begin
			base[k] = 3'(base[k-1] + fifoDepthSel[k-1] + 3'h1);
		end

		// Interface clock: internal divider or sampled pin
		s_next.clkOe_n = !ifaceInternalClk;
		tick = 1'b0;
		if (ifaceInternalClk) begin
			if (s_reg.divCnt >= (ifaceClkFast ? HALF_FAST : HALF_SLOW) - 8'h1) begin
				s_next.divCnt = 8'h0;
				s_next.clkOut = !s_reg.clkOut;
				tick = !s_reg.clkOut;
			end else begin
				s_next.divCnt = s_reg.divCnt + 8'h1;
			end
		end else begin
			s_next.divCnt = 8'h0;
			s_next.clkOut = 1'b0;
			tick = s_reg.sync2[`EFB_PIN_CLK] & !s_reg.clkPrev;
		end

		// Active FIFO: engine address in master, pins in slave
		sel = ifaceMasterMode ? s_reg.addrOut : s_reg.sync2[`EFB_PIN_ADDR +: 2];
		blk = 3'(base[sel] + s_reg.curIdx[sel]);
		isIn = sel[1];

		// Transfer strobes from the selected source
		opRd = 1'b0;
		opWr = 1'b0;
		opPe = 1'b0;
		s_next.strobe = 1'b0;
		if (ifaceMasterMode) begin
			if (tick && s_reg.mst == EFB_MST_XFER && s_reg.sync2[`EFB_PIN_RDY + 32'(sel)]) begin
				opRd = !isIn & s_reg.owner[blk];
				opWr = isIn & stageInReady;
				s_next.strobe = opRd | opWr;
			end
		end else if (tick && !s_reg.sync2[`EFB_PIN_CS]) begin
			opRd = s_reg.sync2[`EFB_PIN_RD] & !isIn;
			opWr = s_reg.sync2[`EFB_PIN_WR] & isIn;
			opPe = s_reg.sync2[`EFB_PIN_PE] & isIn;
		end

		// Pushes into the staging FIFO
		stageInValid = opWr | opPe;
		stageIn = {sel, opWr, opPe, s_reg.sync2[`EFB_PIN_DATA +: `EFB_WORD_W]};

		// Read side: drain the I/O-owned block, then hand it back to USB
		if (opRd && s_reg.owner[blk]) begin
			if ({1'b0, s_reg.ioPtr[sel]} + 9'h1 >= s_reg.wordCount[blk]) begin
				s_next.owner[blk] = 1'b0;
				s_next.ioPtr[sel] = '0;
				s_next.curIdx[sel] = (s_reg.curIdx[sel] == fifoDepthSel[sel]) ? 2'h0 :
					s_reg.curIdx[sel] + 2'h1;
			end else begin
				s_next.ioPtr[sel] = s_reg.ioPtr[sel] + 8'h1;
			end
		end

		// Write side: staged entries fill the current block of their FIFO
		dFifo = stageOut[`EFB_ENT_FIFO +: 2];
		dBlk = 3'(base[dFifo] + s_reg.curIdx[dFifo]);
		stageOutReady = s_reg.owner[dBlk];
		drainWrite = stageOutValid & stageOutReady & stageOut[`EFB_ENT_HAS];
		if (stageOutValid && stageOutReady) begin
			if (stageOut[`EFB_ENT_PE] || (drainWrite && s_reg.ioPtr[dFifo] == 8'hff)) begin
				s_next.wordCount[dBlk] = {1'b0, s_reg.ioPtr[dFifo]} + 9'(drainWrite);
				s_next.owner[dBlk] = 1'b0;
				s_next.ioPtr[dFifo] = '0;
				s_next.curIdx[dFifo] = (s_reg.curIdx[dFifo] == fifoDepthSel[dFifo]) ? 2'h0 :
					s_reg.curIdx[dFifo] + 2'h1;
			end else if (drainWrite) begin
				s_next.ioPtr[dFifo] = s_reg.ioPtr[dFifo] + 8'h1;
			end
		end

		// USB hands a block to the I/O side; refused if already there
		s_next.giveRefused = 1'b0;
		if (usbGive) begin
			if (s_reg.owner[usbBlock]) begin
				s_next.giveRefused = 1'b1;
			end else begin
				s_next.owner[usbBlock] = 1'b1;
				s_next.wordCount[usbBlock] = usbGiveCount;
			end
		end

		// Status flags for the selected FIFO
		s_next.flagSecond = isIn & !stageInReady;
		s_next.flagThird = isIn ? (!stageOutValid && s_reg.ioPtr[sel] == 8'h0) :
			!s_reg.owner[blk];

		// Data pins driven for an outgoing FIFO: always in master mode, in slave mode only under chip select and output enable
		if (ifaceMasterMode) begin
			s_next.dataOe_n = isIn;
		end else begin
			s_next.dataOe_n = !(!s_reg.sync2[`EFB_PIN_CS] & s_reg.sync2[`EFB_PIN_OE] & !isIn);
		end

		// Waveform engine walks the four FIFOs
		s_next.addrOe_n = !ifaceMasterMode;
		if (!ifaceMasterMode) begin
			s_next.mst = EFB_MST_IDLE;
		end else if (tick) begin
			unique case (s_reg.mst)
				EFB_MST_IDLE: s_next.mst = EFB_MST_ADDR;
				EFB_MST_ADDR: s_next.mst = EFB_MST_XFER;
				EFB_MST_XFER: begin
					// Stay while words keep moving
					if (!(opRd | opWr)) begin
						s_next.mst = EFB_MST_NEXT;
					end
				end
				EFB_MST_NEXT: begin
					s_next.addrOut = s_reg.addrOut + 2'h1;
					s_next.mst = EFB_MST_ADDR;
				end
			endcase
		end

		// Endpoint report
		{s_next.epSize, s_next.epType, s_next.epDouble} = ep_report(epQuery, altSetting,
			highSpeed);
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register

	// Reset strikes at once; the rest waits for the synchronised release
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			s_reg <= STATE_RESET;
		end else if (!rst_n) begin
			// Only the release pipe moves while the synchronised reset is low
			s_reg <= STATE_RESET;
			s_reg.rstPipe <= s_next.rstPipe;
		end else begin
			s_reg <= s_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Block RAM: one write path per domain, registered reads

	// USB side reaches only blocks it owns; I/O side reads and writes at once
	always_ff @(posedge ref_clk) begin
		if (usbWrite && !s_reg.owner[usbBlock]) begin
			ram[{usbBlock, usbAddr}] <= usbWrData;
		end
		if (drainWrite) begin
			ram[{dBlk, s_reg.ioPtr[dFifo]}] <= stageOut[`EFB_WORD_W-1:0];
		end
	end

	// Read ports, cleared under reset so outputs start defined
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ioRd_reg <= '0;
			usbRd_reg <= '0;
		end else begin
			ioRd_reg <= ram[{blk, s_reg.ioPtr[sel]}];
			usbRd_reg <= s_reg.owner[usbBlock] ? '0 : ram[{usbBlock, usbAddr}];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign usbRdData = usbRd_reg;
	assign blockOwner = s_reg.owner;
	assign giveRefused = s_reg.giveRefused;
	assign ifaceClkOut = s_reg.clkOut;
	assign ifaceClkOe_n = s_reg.clkOe_n;
	assign fifoSelectAddrOut = s_reg.addrOut;
	assign fifoSelectAddrOe_n = s_reg.addrOe_n;
	assign fifoDataOut = ioRd_reg;
	assign fifoDataOe_n = s_reg.dataOe_n;
	assign fifoFlagSecond = s_reg.flagSecond;
	assign fifoFlagThird = s_reg.flagThird;
	assign waveStrobe = s_reg.strobe;
	assign epSize = s_reg.epSize;
	assign epType = s_reg.epType;
	assign epDouble = s_reg.epDouble;
endmodule

// *** verification/efb_endpoint_fifo_sva.sv ***
// Port-level checks for the endpoint FIFO top module
`timescale 1ns/1ps
`include "efb_regs.svh"
module efb_endpoint_fifo_sva (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Watched inputs
	input wire logic ifaceMasterMode,
	input wire logic ifaceInternalClk,
	input wire logic [`EFB_BLK_W-1:0] usbBlock,
	input wire logic usbGive,
	// Watched outputs
	input wire logic [`EFB_BLOCKS-1:0] blockOwner,
	input wire logic giveRefused,
	input wire logic [`EFB_WORD_W-1:0] usbRdData,
	input wire logic ifaceClkOe_n,
	input wire logic fifoSelectAddrOe_n,
	input wire logic fifoDataOe_n,
	input wire logic fifoFlagSecond,
	input wire logic fifoFlagThird,
	input wire logic waveStrobe
);
	// One clock domain for every check
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	give_sets_owner_a: assert property (usbGive && !blockOwner[usbBlock] |=> blockOwner[$past(usbBlock)]) else $error("give did not move block");
	give_refused_a: assert property (usbGive && blockOwner[usbBlock] |=> giveRefused) else $error("double give not refused");
	refuse_cause_a: assert property (giveRefused |-> $past(usbGive)) else $error("refusal without give");
	io_block_hidden_a: assert property (blockOwner[usbBlock] |=> usbRdData == '0) else $error("usb saw io block");
	reset_quiet_a: assert property ($rose(resetn) |-> fifoDataOe_n && ifaceClkOe_n && fifoSelectAddrOe_n) else $error("pin driven in reset");
	addr_master_a: assert property (ifaceMasterMode [*3] |=> !fifoSelectAddrOe_n) else $error("address not driven");
	addr_slave_a: assert property (!ifaceMasterMode [*3] |=> fifoSelectAddrOe_n) else $error("address driven in slave");
	clk_drive_a: assert property (ifaceInternalClk [*3] |=> !ifaceClkOe_n) else $error("clock not driven");
	strobe_slave_a: assert property (!ifaceMasterMode [*3] |=> !waveStrobe) else $error("strobe in slave");
	full_empty_a: assert property (fifoFlagSecond |-> !fifoFlagThird) else $error("full and empty");
endmodule
bind efb_endpoint_fifo efb_endpoint_fifo_sva u_sva (.ref_clk(ref_clk), .resetn(resetn),
	.ifaceMasterMode(ifaceMasterMode), .ifaceInternalClk(ifaceInternalClk), .usbBlock(usbBlock),
	.usbGive(usbGive), .blockOwner(blockOwner), .giveRefused(giveRefused), .usbRdData(usbRdData),
	.ifaceClkOe_n(ifaceClkOe_n), .fifoSelectAddrOe_n(fifoSelectAddrOe_n),
	.fifoDataOe_n(fifoDataOe_n), .fifoFlagSecond(fifoFlagSecond),
	.fifoFlagThird(fifoFlagThird), .waveStrobe(waveStrobe));

// *** verification/efb_fifo_master_model.sv ***
// External master that strobes the slave FIFO port
`timescale 1ns/1ps
module efb_fifo_master_model (
	// Strobes and clock toward the device
	output logic ifaceClk,
	output logic chipSelect_n,
	output logic readStrobe,
	output logic writeStrobe,
	output logic outputEnable,
	output logic packetEnd,
	// Select address and data toward the device
	output logic [1:0] selAddr,
	output logic [15:0] dataOut
);
	// Idle: clock stands low, nothing selected
	initial begin
		{ifaceClk, readStrobe, writeStrobe, outputEnable, packetEnd} = '0;
		chipSelect_n = 1'b1;
		selAddr = 2'h0;
		dataOut = 16'h0000;
	end

	// Choose a FIFO without any clock edge
	task automatic select(input logic [1:0] sel);
		selAddr = sel;
	endtask

	// One operation on one rising edge of a 200 ns interface clock
	task automatic xfer(input logic rd, input logic wr, input logic pe, input logic [15:0] d);
		chipSelect_n = 1'b0;
		readStrobe = rd;
		writeStrobe = wr;
		packetEnd = pe;
		outputEnable = rd;
		dataOut = d;
		#100 ifaceClk = 1'b1;
		// Release half way through the high phase, so a following call never
		// rewrites a strobe in the same time step; data shows the inverse
		#50 {readStrobe, writeStrobe, packetEnd, outputEnable} = '0;
		chipSelect_n = 1'b1;
		dataOut = ~d;
		#50 ifaceClk = 1'b0;
	endtask
endmodule

// *** verification/efb_endpoint_fifo_tb_top.sv ***
// Self-checking bench for the endpoint FIFO block
`timescale 1ns/1ps
module efb_endpoint_fifo_tb_top;
	import efb_pkg::*;
	// Clock, reset and design inputs
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic ifaceMasterMode = 0, ifaceInternalClk = 0, ifaceClkFast = 0, highSpeed = 0;
	logic [3:0][1:0] fifoDepthSel = '0;
	logic [1:0] altSetting = 2'h0;
	logic [2:0] epQuery = 3'h0, usbBlock = 3'h0;
	logic [7:0] usbAddr = 8'h00, blockOwner;
	logic usbWrite = 0, usbGive = 0, giveRefused, ifaceClkOut, ifaceClkOe_n;
	logic [15:0] usbWrData = 16'h0000, usbRdData, fifoDataIn, fifoDataOut, hostData, tmp;
	logic [8:0] usbGiveCount = 9'h000;
	logic [5:0] readyIn = 6'h00;
	logic iface_clk, csN, rdS, wrS, oeS, peS, dataOe_n, addrOe_n, flagSecond, flagThird, waveStrobe;
	logic [1:0] selAddr, addrOut;
	logic [9:0] epSize;
	efb_ep_type_t epType;
	logic epDouble;
	int failures = 0;
	int num_checks = 0;

	// 40 MHz clock
	always #12.5 ref_clk = ~ref_clk;
	// Shared data wire: device wins while it drives
	assign fifoDataIn = dataOe_n ? hostData : fifoDataOut;

	efb_fifo_master_model mst (.ifaceClk(iface_clk), .chipSelect_n(csN), .readStrobe(rdS),
		.writeStrobe(wrS), .outputEnable(oeS), .packetEnd(peS), .selAddr(selAddr),
		.dataOut(hostData));

	efb_endpoint_fifo DUT (.ref_clk(ref_clk), .resetn(resetn), .ifaceMasterMode(ifaceMasterMode),
		.ifaceInternalClk(ifaceInternalClk), .ifaceClkFast(ifaceClkFast),
		.fifoDepthSel(fifoDepthSel), .altSetting(altSetting), .highSpeed(highSpeed),
		.epQuery(epQuery), .usbBlock(usbBlock), .usbAddr(usbAddr), .usbWrite(usbWrite),
		.usbWrData(usbWrData), .usbGive(usbGive), .usbGiveCount(usbGiveCount),
		.usbRdData(usbRdData), .blockOwner(blockOwner), .giveRefused(giveRefused),
		.ifaceClkIn(iface_clk), .ifaceClkOut(ifaceClkOut), .ifaceClkOe_n(ifaceClkOe_n),
		.fifoChipSelect_n(csN), .fifoReadStrobe(rdS), .fifoWriteStrobe(wrS),
		.fifoOutputEnable(oeS), .packetEndStrobe(peS), .fifoSelectAddrIn(selAddr),
		.fifoSelectAddrOut(addrOut), .fifoSelectAddrOe_n(addrOe_n), .fifoDataIn(fifoDataIn),
		.fifoDataOut(fifoDataOut), .fifoDataOe_n(dataOe_n), .readyIn(readyIn),
		.fifoFlagSecond(flagSecond), .fifoFlagThird(flagThird), .waveStrobe(waveStrobe),
		.epSize(epSize), .epType(epType), .epDouble(epDouble));

	////////////////////////////////////////////////////////////////////////////////
	// Compare and close
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// USB side single-port accesses
	task automatic usb_write(input logic [2:0] b, input logic [7:0] a, input logic [15:0] d);
		@(negedge ref_clk) {usbBlock, usbAddr, usbWrData, usbWrite} = {b, a, d, 1'b1};
		@(negedge ref_clk) usbWrite = 1'b0;
	endtask
	task automatic usb_give(input logic [2:0] b, input logic [8:0] n);
		@(negedge ref_clk) {usbBlock, usbGiveCount, usbGive} = {b, n, 1'b1};
		@(negedge ref_clk) usbGive = 1'b0;
	endtask
	task automatic usb_read(input logic [2:0] b, input logic [7:0] a, output logic [15:0] d);
		@(negedge ref_clk) {usbBlock, usbAddr} = {b, a};
		@(negedge ref_clk) d = usbRdData;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic test_reset();
		check("flagSecond", flagSecond, 0);
		check("flagThird", flagThird, 1);
		check("blockOwner", blockOwner, 0);
		check("dataOe_n", dataOe_n, 1);
	endtask

	// Endpoint size, type and buffering table
	task automatic test_report();
		for (int h = 0; h < 2; h++) for (int a = 0; a < 4; a++) for (int e = 0; e < 7; e++) begin
			@(negedge ref_clk) {highSpeed, altSetting, epQuery} = {h[0], a[1:0], e[2:0]};
			repeat (3) @(negedge ref_clk);
			tmp = (e == 0) ? 64 : (a == 0) ? 0 : (e < 3 && !(h == 1 && a == 1)) ? 64 : h ? 512 : 64;
			check("epSize", epSize, tmp);
			if (e == 0 || a != 0) begin
				tmp = (e == 0) ? EFB_EP_CTRL : (a == 1 || e == 4 || e == 6) ? EFB_EP_BULK :
					(e < 3 || a == 2) ? EFB_EP_INTR : EFB_EP_ISO;
				check("epType", epType, tmp);
				check("epDouble", epDouble, e > 2);
			end
		end
	endtask

	// USB fills block 0, slave port reads it out as FIFO 0
	task automatic test_out_read();
		usb_write(3'h0, 8'h00, 16'h1234);
		usb_write(3'h0, 8'h01, 16'habcd);
		usb_give(3'h0, 9'h002);
		check("owner0", blockOwner[0], 1);
		usb_give(3'h0, 9'h002);
		check("giveRefused", giveRefused, 1);
		mst.select(2'h0);
		repeat (8) @(negedge ref_clk);
		check("flagThird", flagThird, 0);
		check("flagSecond", flagSecond, 0);
		check("word0", fifoDataOut, 16'h1234);
		mst.xfer(1, 0, 0, 16'h0000);
		repeat (6) @(negedge ref_clk);
		check("word1", fifoDataOut, 16'habcd);
		mst.xfer(1, 0, 0, 16'h0000);
		repeat (6) @(negedge ref_clk);
		check("drained", flagThird, 1);
	endtask

	// Slave port writes FIFO 2, packet end hands block 2 back to USB
	task automatic test_in_write();
		usb_give(3'h2, 9'h000);
		mst.select(2'h2);
		repeat (8) @(negedge ref_clk);
		check("inEmpty", flagThird, 1);
		mst.xfer(0, 1, 0, 16'h5a01);
		mst.xfer(0, 1, 0, 16'h5a02);
		mst.xfer(0, 0, 1, 16'h0000);
		repeat (10) @(negedge ref_clk);
		check("owner2", blockOwner[2], 0);
		usb_read(3'h2, 8'h00, tmp);
		check("inWord0", tmp, 16'h5a01);
		usb_read(3'h2, 8'h01, tmp);
		check("inWord1", tmp, 16'h5a02);
	endtask

	// Waveform engine with internal interface clock at both rates
	task automatic test_master();
		int seen;
		int flips;
		seen = 0;
		@(negedge ref_clk) {ifaceMasterMode, ifaceInternalClk, readyIn} = {2'b11, 6'h3f};
		for (int i = 0; i < 300 && seen == 0; i++) @(negedge ref_clk) seen = waveStrobe;
		check("waveStrobe", seen, 1);
		check("addrOut", addrOut, 16'h2);
		check("addrOe_n", addrOe_n, 0);
		check("clkOe_n", ifaceClkOe_n, 0);
		for (int f = 0; f < 2; f++) begin
			@(negedge ref_clk) ifaceClkFast = f[0];
			repeat (4) @(negedge ref_clk);
			flips = 0;
			for (int i = 0; i < 8; i++) begin
				tmp[0] = ifaceClkOut;
				@(negedge ref_clk) flips += (ifaceClkOut !== tmp[0]);
			end
			check("clkFlips", flips, 8);
		end
		// Engine fills FIFO 2 while its block sits with USB, until staging is full
		repeat (40) @(negedge ref_clk);
		ifaceMasterMode = 1'b0;
		repeat (8) @(negedge ref_clk);
		check("full", flagSecond, 1);
		check("notEmpty", flagThird, 0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence and watchdog
	initial begin
		repeat (16) @(negedge ref_clk);
		resetn = 1'b1;
		repeat (6) @(negedge ref_clk);
		test_reset();
		test_report();
		test_out_read();
		test_in_write();
		test_master();
		tally_and_finish();
	end
	initial begin
		#500000;
		failures++;
		tally_and_finish();
	end
endmodule
